/* File: hw/qdcd_top.sv */
// Purpose: Command decoder and channel register bank of a quad 12-bit converter.
// Assumes: Bytes are delivered on the acknowledge falling edge; external load strobe is asynchronous.
// Notes: A FIFO decouples the byte receiver from the decoder; UPDATE_HOLD stalls draining.
//
// What this block does
// - Hold received command byte in eight-bit register.
// - Mode 00: write staging only, output unchanged.
// - Channel pick 00..11 selects channels A..D.
// - Mode 01: write staging and output of one.
// - Mode 10: write staging, load all outputs.
// - Broadcast, pick high 0: outputs from staging.
// - Broadcast, pick high 1: new data everywhere.
// - Broadcast, pick high 1, power-down flag: power-down all.
// - Upper data byte gives top eight bits.
// - Power-down flag: upper byte top bits are code.
// - Lower byte high nibble gives low bits.
// - Commit after second data byte is acknowledged.
// - Readback storage clears to zero at reset.
// - External load rising edge copies all staging.
// - Fourteen-bit staging register per channel.
// - Fourteen-bit output register per channel, immediate effect.
// - Upper byte register may hold power-down code.
`timescale 1ns/10ps
`default_nettype none

module qdcd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (!push && pop) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap naturally, so DEPTH must be a power of two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Flags are registered from the next count so both ports see flop outputs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule

module qdcd_top
    import qdcd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    input wire logic BYTE_FIRST,
    output logic BYTE_READY,
    input wire logic UPDATE_HOLD,
    input wire logic [1:0] EXT_ADDR_PINS,
    input wire logic EXT_LOAD_STROBE,
    input wire logic [1:0] READ_CHAN,
    output logic [REG_W-1:0] READ_DATA,
    output logic [7:0] COMMAND_BYTE,
    output logic [REG_W-1:0] OUT_CODE_A,
    output logic [REG_W-1:0] OUT_CODE_B,
    output logic [REG_W-1:0] OUT_CODE_C,
    output logic [REG_W-1:0] OUT_CODE_D
);
    typedef enum logic [1:0] {
        PS_WAIT_CMD,
        PS_WAIT_UPPER,
        PS_WAIT_LOWER,
        PS_COMMIT
    } qdcd_state_t;

    qdcd_state_t state;
    logic [7:0] command_byte;
    logic [7:0] upper_data_byte;
    logic [7:0] lower_data_byte;
    logic [REG_W-1:0] staging_reg [CHANNELS];
    logic [REG_W-1:0] output_channel [CHANNELS];
    logic [REG_W-1:0] read_data;

    logic fifo_valid;
    logic [ENTRY_W-1:0] fifo_entry;
    logic fifo_pop;
    logic entry_first;
    logic [7:0] entry_byte;

    logic ld_meta;
    logic ld_sync;
    logic ld_prev;
    logic ext_load_strobe;

    logic commit;
    logic [1:0] update_mode;
    logic [1:0] chan_pick;
    logic powerdown_flag;
    logic addr_match;
    logic broadcast;
    logic [PD_W-1:0] powerdown_code;
    logic [CODE_W-1:0] new_code;

    qdcd_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst(RST),
        .in_valid(BYTE_VALID),
        .in_data({BYTE_FIRST, BYTE_DATA}),
        .in_ready(BYTE_READY),
        .out_valid(fifo_valid),
        .out_data(fifo_entry),
        .out_ready(fifo_pop)
    );

    assign entry_first = fifo_entry[ENTRY_FIRST_BIT];
    assign entry_byte = fifo_entry[7:0];
    // The commit cycle takes no byte, which also lets the decoder apply back-pressure.
    assign fifo_pop = fifo_valid && !UPDATE_HOLD && (state != PS_COMMIT);

    // The strobe is asynchronous, so it is synchronised before its rising edge is taken.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ld_meta <= 1'b0;
            ld_sync <= 1'b0;
            ld_prev <= 1'b0;
        end else begin
            ld_meta <= EXT_LOAD_STROBE;
            ld_sync <= ld_meta;
            ld_prev <= ld_sync;
        end
    end

    assign ext_load_strobe = ld_sync && !ld_prev;

    // A byte flagged first always restarts the sequence, so a cut-short transfer leaves no commit.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= PS_WAIT_CMD;
        end else begin
            case (state)
                PS_WAIT_CMD: begin
                    if (fifo_pop && entry_first) begin
                        state <= PS_WAIT_UPPER;
                    end
                end
                PS_WAIT_UPPER: begin
                    // A new command here opens a fresh transfer, so its first data byte is still the upper one.
                    if (fifo_pop && entry_first) begin
                        state <= PS_WAIT_UPPER;
                    end else if (fifo_pop) begin
                        state <= PS_WAIT_LOWER;
                    end
                end
                PS_WAIT_LOWER: begin
                    if (fifo_pop && entry_first) begin
                        state <= PS_WAIT_UPPER;
                    end else if (fifo_pop) begin
                        state <= PS_COMMIT;
                    end
                end
                PS_COMMIT: begin
                    state <= PS_WAIT_UPPER;
                end
                default: begin
                    state <= PS_WAIT_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            command_byte <= BYTE_RESET;
            upper_data_byte <= BYTE_RESET;
            lower_data_byte <= BYTE_RESET;
        end else if (fifo_pop) begin
            if (entry_first) begin
                command_byte <= entry_byte;
            end else if (state == PS_WAIT_UPPER) begin
                upper_data_byte <= entry_byte;
            end else if (state == PS_WAIT_LOWER) begin
                lower_data_byte <= entry_byte;
            end
        end
    end

    assign commit = (state == PS_COMMIT);
    assign update_mode = {command_byte[CMD_MODE_HI_BIT], command_byte[CMD_MODE_LO_BIT]};
    assign chan_pick = {command_byte[CMD_PICK_HI_BIT], command_byte[CMD_PICK_LO_BIT]};
    assign powerdown_flag = command_byte[CMD_PDFLAG_BIT];
    assign broadcast = (update_mode == MODE_BROADCAST);
    // Broadcast commands are taken whatever the extended address says.
    assign addr_match = ({command_byte[CMD_EXT_HI_BIT], command_byte[CMD_EXT_LO_BIT]} == EXT_ADDR_PINS);
    assign powerdown_code = upper_data_byte[UPPER_PD_HI_BIT:UPPER_PD_LO_BIT];
    assign new_code = {upper_data_byte, lower_data_byte[LOWER_NIB_HI_BIT:LOWER_NIB_LO_BIT]};

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic picked;
        logic stage_we;
        logic out_we;
        logic out_copy;
        logic [REG_W-1:0] new_value;
        logic [REG_W-1:0] next_stage;

        assign picked = (chan_pick == 2'(ch));
        // A power-down command keeps the stored code so a later load can resume it.
        assign new_value = powerdown_flag
            ? {powerdown_code, staging_reg[ch][CODE_W-1:0]}
            : {PD_NORMAL, new_code};
        assign stage_we = commit && ((!broadcast && addr_match && picked)
            || (broadcast && chan_pick[1]));
        assign out_we = commit && ((update_mode == MODE_LOAD_ONE && addr_match && picked)
            || (broadcast && chan_pick[1]));
        assign out_copy = ext_load_strobe
            || (commit && update_mode == MODE_LOAD_ALL && addr_match)
            || (commit && broadcast && !chan_pick[1]);
        assign next_stage = stage_we ? new_value : staging_reg[ch];

        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                staging_reg[ch] <= REG_RESET;
            end else begin
                staging_reg[ch] <= next_stage;
            end
        end

        // A same-cycle command write to this output wins over a copy from staging.
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                output_channel[ch] <= REG_RESET;
            end else if (out_we) begin
                output_channel[ch] <= new_value;
            end else if (out_copy) begin
                output_channel[ch] <= next_stage;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            read_data <= REG_RESET;
        end else begin
            read_data <= output_channel[READ_CHAN];
        end
    end

    assign READ_DATA = read_data;
    assign COMMAND_BYTE = command_byte;
    assign OUT_CODE_A = output_channel[0];
    assign OUT_CODE_B = output_channel[1];
    assign OUT_CODE_C = output_channel[2];
    assign OUT_CODE_D = output_channel[3];
endmodule

`default_nettype wire

/* File: shared/qdcd_pkg.sv */
// Purpose: Shared constants for the quad-channel converter command decoder.
// Assumes: Command, upper and lower data bytes arrive in bus order from an external byte receiver.
// Notes: Field positions follow the command byte layout, from the high bit down.
`default_nettype none

package qdcd_pkg;
    localparam int CODE_W = 12;
    localparam int PD_W = 2;
    localparam int REG_W = 14;
    localparam int CHANNELS = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int ENTRY_W = 9;
    localparam int ENTRY_FIRST_BIT = 8;

    localparam int CMD_EXT_HI_BIT = 7;
    localparam int CMD_EXT_LO_BIT = 6;
    localparam int CMD_MODE_HI_BIT = 5;
    localparam int CMD_MODE_LO_BIT = 4;
    localparam int CMD_PICK_HI_BIT = 2;
    localparam int CMD_PICK_LO_BIT = 1;
    localparam int CMD_PDFLAG_BIT = 0;

    localparam int UPPER_PD_HI_BIT = 7;
    localparam int UPPER_PD_LO_BIT = 6;
    localparam int LOWER_NIB_HI_BIT = 7;
    localparam int LOWER_NIB_LO_BIT = 4;
    localparam int REG_PD_HI_BIT = 13;
    localparam int REG_PD_LO_BIT = 12;

    localparam logic [1:0] MODE_STAGE_ONLY = 2'h0;
    localparam logic [1:0] MODE_LOAD_ONE = 2'h1;
    localparam logic [1:0] MODE_LOAD_ALL = 2'h2;
    localparam logic [1:0] MODE_BROADCAST = 2'h3;

    localparam logic [PD_W-1:0] PD_NORMAL = 2'h0;
    localparam logic [REG_W-1:0] REG_RESET = 14'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

`default_nettype wire

/* File: test/qdcd_master_model.sv */
// Purpose: Byte source standing in for the bus master behind the byte receiver.
// Assumes: Bytes change on the falling clock edge.
// Notes: A released byte shows its inverse, so a stale value is never read as fresh.
`timescale 1ns/10ps
`default_nettype none
module qdcd_master_model (
    input wire logic clk,
    input wire logic ready,
    output logic valid = 1'b0,
    output logic [7:0] data = 8'h00,
    output logic first = 1'b0
);
    task automatic send(input logic f, input logic [7:0] b);
        @(negedge clk);
        valid = 1'b1;
        data = b;
        first = f;
        while (!ready) @(negedge clk);
        @(posedge clk);
    endtask
    task automatic idle();
        @(negedge clk);
        valid = 1'b0;
        data = ~data;
        first = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test/qdcd_monitor.sv */
// Purpose: Port checks of the quad converter command decoder.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Channel checks apply only once the strobe and command byte have settled.
`timescale 1ns/10ps
`default_nettype none
module qdcd_monitor
    import qdcd_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic BYTE_VALID,
    input wire logic BYTE_READY,
    input wire logic UPDATE_HOLD,
    input wire logic EXT_LOAD_STROBE,
    input wire logic [1:0] READ_CHAN,
    input wire logic [REG_W-1:0] READ_DATA,
    input wire logic [7:0] COMMAND_BYTE,
    input wire logic [REG_W-1:0] OUT_CODE_A,
    input wire logic [REG_W-1:0] OUT_CODE_B,
    input wire logic [REG_W-1:0] OUT_CODE_C,
    input wire logic [REG_W-1:0] OUT_CODE_D
);
    logic [REG_W-1:0] outs [4];
    logic [REG_W-1:0] prev [4];
    logic [3:0] chg;
    logic [7:0] prev_cmd;
    logic [5:0] sq, bq;
    logic prev_strobe, pd_any, calm, bc;
    logic [1:0] mode, pick;
    always_comb begin
        outs = '{OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D};
        mode = COMMAND_BYTE[CMD_MODE_HI_BIT:CMD_MODE_LO_BIT];
        pick = COMMAND_BYTE[CMD_PICK_HI_BIT:CMD_PICK_LO_BIT];
        bc = mode == MODE_BROADCAST && COMMAND_BYTE[CMD_PICK_HI_BIT];
        calm = sq >= 6'h04 && COMMAND_BYTE == prev_cmd;
        pd_any = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            chg[i] = outs[i] != prev[i];
            pd_any = pd_any | (chg[i] && outs[i][REG_PD_HI_BIT:REG_PD_LO_BIT] != PD_NORMAL);
        end
    end
    // Strobe updates land three edges late, so the quiet count waits four.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            prev <= '{default: '0};
            prev_cmd <= 8'h00;
            prev_strobe <= 1'b0;
            sq <= 6'h00;
            bq <= 6'h00;
        end else begin
            prev <= outs;
            prev_cmd <= COMMAND_BYTE;
            prev_strobe <= EXT_LOAD_STROBE;
            sq <= (EXT_LOAD_STROBE != prev_strobe) ? 6'h00 : sq + {5'h00, sq != 6'h3F};
            bq <= (BYTE_VALID && BYTE_READY || UPDATE_HOLD) ? 6'h00 : bq + {5'h00, bq != 6'h3F};
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence settled_s;
        calm;
    endsequence
    stage_only_a: assert property (settled_s ##0 mode == MODE_STAGE_ONLY |-> chg == 4'h0)
        else $error("stage-only command moved an output");
    one_chan_a: assert property (settled_s ##0 mode == MODE_LOAD_ONE |-> (chg & ~(4'h1 << pick)) == 4'h0)
        else $error("single load moved another channel");
    pd_clear_a: assert property (settled_s ##0 !COMMAND_BYTE[0] && (mode == MODE_LOAD_ONE || bc) |-> !pd_any)
        else $error("normal write left a power-down field");
    bcast_data_a: assert property (settled_s ##0 bc && !COMMAND_BYTE[0] && chg != 4'h0 |->
        OUT_CODE_A == OUT_CODE_B && OUT_CODE_B == OUT_CODE_C && OUT_CODE_C == OUT_CODE_D)
        else $error("broadcast data differs between channels");
    bcast_pd_a: assert property (settled_s ##0 bc && COMMAND_BYTE[0] && chg != 4'h0 |->
        OUT_CODE_A[13:12] == OUT_CODE_B[13:12] && OUT_CODE_B[13:12] == OUT_CODE_C[13:12]
        && OUT_CODE_C[13:12] == OUT_CODE_D[13:12])
        else $error("broadcast power-down differs between channels");
    quiet_hold_a: assert property (bq >= 6'h28 && sq >= 6'h04 |-> chg == 4'h0)
        else $error("output moved without a transfer");
    cmd_cause_a: assert property ($changed(COMMAND_BYTE) |-> bq < 6'h28)
        else $error("command byte changed without a transfer");
    readback_a: assert property (1'b1 |=> READ_DATA == $past(outs[READ_CHAN]))
        else $error("readback does not follow output register");
    reset_zero_a: assert property ($fell(RST) |-> {OUT_CODE_A, OUT_CODE_B, OUT_CODE_C, OUT_CODE_D} == '0)
        else $error("output not zero after reset");
endmodule
bind qdcd_top qdcd_monitor u_monitor (.MCLK(MCLK), .RST(RST), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
    .UPDATE_HOLD(UPDATE_HOLD), .EXT_LOAD_STROBE(EXT_LOAD_STROBE), .READ_CHAN(READ_CHAN), .READ_DATA(READ_DATA),
    .COMMAND_BYTE(COMMAND_BYTE), .OUT_CODE_A(OUT_CODE_A), .OUT_CODE_B(OUT_CODE_B), .OUT_CODE_C(OUT_CODE_C),
    .OUT_CODE_D(OUT_CODE_D));
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the quad converter command decoder.
// Assumes: The byte source model delivers commands; bench functions give expectations.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import qdcd_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, hold = 1'b0, strobe = 1'b0;
    logic [1:0] addr = 2'h0, rchan = 2'h0;
    logic valid, first, ready;
    logic [7:0] data, cmd_seen, c;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] outs [4];
    logic [REG_W-1:0] st [4] = '{default: '0};
    logic [REG_W-1:0] dr [4] = '{default: '0};
    int errors = 0, tests_run = 0, cycles = 0, seed = 76;
    always #50 mclk = ~mclk;
    qdcd_master_model src (.clk(mclk), .ready(ready), .valid(valid), .data(data), .first(first));
    qdcd_top dut (.MCLK(mclk), .RST(rst), .BYTE_VALID(valid), .BYTE_DATA(data), .BYTE_FIRST(first),
        .BYTE_READY(ready), .UPDATE_HOLD(hold), .EXT_ADDR_PINS(addr), .EXT_LOAD_STROBE(strobe),
        .READ_CHAN(rchan), .READ_DATA(rdata), .COMMAND_BYTE(cmd_seen), .OUT_CODE_A(outs[0]),
        .OUT_CODE_B(outs[1]), .OUT_CODE_C(outs[2]), .OUT_CODE_D(outs[3]));
    function automatic logic [REG_W-1:0] word_of(logic [7:0] k, logic [7:0] u, logic [7:0] l, logic [13:0] old);
        return k[0] ? {u[7:6], old[11:0]} : {2'h0, u, l[7:4]};
    endfunction
    task automatic model(input logic [7:0] k, input logic [7:0] u, input logic [7:0] l);
        logic [1:0] p;
        p = k[2:1];
        if (k[5:4] == 2'h3) begin
            for (int i = 0; i < 4; i++) begin
                if (k[2]) st[i] = word_of(k, u, l, st[i]);
                dr[i] = st[i];
            end
        end else if (k[7:6] == addr) begin
            st[p] = word_of(k, u, l, st[p]);
            if (k[5:4] == 2'h1) dr[p] = st[p];
            if (k[5:4] == 2'h2) dr = st;
        end
    endtask
    task automatic check(input string name, input logic [REG_W-1:0] exp, input logic [REG_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_all();
        repeat (30) @(negedge mclk);
        for (int i = 0; i < 4; i++) begin
            rchan = 2'(i);
            repeat (2) @(negedge mclk);
            check("output", dr[i], outs[i]);
            check("readback", dr[i], rdata);
        end
    endtask
    task automatic xfer(input logic [7:0] k, input logic [7:0] u, input logic [7:0] l);
        src.send(1'b1, k);
        src.send(1'b0, u);
        src.send(1'b0, l);
        src.idle();
        model(k, u, l);
        check_all();
        check("command", {6'h0, k}, {6'h0, cmd_seen});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        addr = 2'($random(seed));
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        check_all();
        for (int k = 0; k < 64; k++) begin
            c = {k[5] ? 2'($random(seed)) : addr, 2'(k >> 3), 1'($random(seed)), 2'(k >> 1), k[0]};
            xfer(c, 8'($random(seed)), 8'($random(seed)));
        end
        src.send(1'b1, {addr, 6'h12});
        src.send(1'b0, 8'hA5);
        xfer({addr, 6'h10}, 8'h3C, 8'hF0);
        for (int i = 0; i < 4; i++) xfer({addr, 3'h0, 2'(i), 1'b0}, 8'($random(seed)), 8'h90);
        strobe = 1'b1;
        repeat (2) @(negedge mclk);
        strobe = 1'b0;
        dr = st;
        check_all();
        // Sixteen bytes with draining stalled: the buffer must refuse more.
        hold = 1'b1;
        src.send(1'b1, {addr, 6'h14});
        for (int i = 0; i < 7; i++) begin
            c = 8'($random(seed));
            src.send(1'b0, c);
            src.send(1'b0, ~c);
            model({addr, 6'h14}, c, ~c);
        end
        src.send(1'b0, 8'hFF);
        src.idle();
        @(negedge mclk);
        check("ready", '0, {13'h0, ready});
        hold = 1'b0;
        check_all();
        xfer({addr, 6'h02}, 8'h12, 8'h30);
        tally_and_finish();
    end
endmodule
`default_nettype wire
